// File: include/counter_array_pkg.sv
package counter_array_pkg;

    // Register offsets on the plain register port
    localparam logic [7:0] OFS_COUNTER_MODE = 8'h00;
    localparam logic [7:0] OFS_COUNTER_CONTROL = 8'h01;
    localparam logic [7:0] OFS_COUNT_LOW = 8'h02;
    localparam logic [7:0] OFS_COUNT_HIGH = 8'h03;
    localparam logic [7:0] OFS_MODULE_MODE_BASE = 8'h08;
    localparam logic [7:0] OFS_CAPTURE_LOW_BASE = 8'h10;
    localparam logic [7:0] OFS_CAPTURE_HIGH_BASE = 8'h18;

    // counter_mode_reg fields
    localparam int IDLE_HALT_BIT = 7;
    localparam int WATCHDOG_ENABLE_BIT = 6;
    localparam int SOURCE_SELECT_HI_BIT = 2;
    localparam int SOURCE_SELECT_LO_BIT = 1;
    localparam int OVERFLOW_IRQ_ENABLE_BIT = 0;
    localparam logic [7:0] COUNTER_MODE_MASK = 8'hc7;

    // counter_control_reg fields
    localparam int OVERFLOW_FLAG_BIT = 7;
    localparam int RUN_CONTROL_BIT = 6;

    // module_mode_reg fields
    localparam int COMPARATOR_ENABLE_BIT = 6;
    localparam int RISE_EDGE_ENABLE_BIT = 5;
    localparam int FALL_EDGE_ENABLE_BIT = 4;
    localparam int COMPARE_HIT_FLAG_ENABLE_BIT = 3;
    localparam int INVERT_OUTPUT_ON_HIT_BIT = 2;
    localparam int MODULATION_BIT = 1;
    localparam int MODULE_IRQ_ENABLE_BIT = 0;
    localparam logic [7:0] MODULE_MODE_MASK = 8'h7f;

    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_COUNT = 16'h0000;

    // Port 1 pin positions
    localparam int EXT_COUNT_PIN = 2;
    localparam int MODULE_PIN_BASE = 3;
    localparam int NUM_MODULES = 5;
    localparam int WATCHDOG_MODULE = 4;

    // Prescaler: clock / 6 and clock / 2 from one mod-6 counter
    localparam logic [2:0] PRESCALE_LAST = 3'h5;
    localparam logic [2:0] PRESCALE_ZERO = 3'h0;

    typedef enum logic [1:0] {
        SRC_CLK_DIV6 = 2'h0,
        SRC_CLK_DIV2 = 2'h1,
        SRC_TIMER0_OVERFLOW = 2'h2,
        SRC_EXTERNAL_INPUT = 2'h3
    } count_source_e;

endpackage

// File: logic/pin_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync #(
    parameter int WIDTH = 6
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] pins,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
        logic [WIDTH-1:0] prev;
    } sync_s;

    sync_s state_q;
    sync_s state_d;

    always_comb begin
        state_d = state_q;
        state_d.meta = pins;
        state_d.stable = state_q.meta;
        state_d.prev = state_q.stable;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            // Idle pins sit high, so resetting low would fake a rising edge
            state_q <= '1;
        end else begin
            state_q <= state_d;
        end
    end

    // Edges judged from the two settled samples only
    assign level = state_q.stable;
    assign rise = state_q.stable & ~state_q.prev;
    assign fall = ~state_q.stable & state_q.prev;

endmodule
`default_nettype wire

// File: logic/capture_compare_channel.sv
`timescale 1ns/1ps
`default_nettype none
module capture_compare_channel (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [15:0] count,
    input wire logic fresh,
    input wire logic low_wrap,
    input wire logic pin_rise,
    input wire logic pin_fall,
    input wire logic wr_mode,
    input wire logic wr_low,
    input wire logic wr_high,
    input wire logic [7:0] wdata,
    output logic [7:0] mode,
    output logic [7:0] capture_low,
    output logic [7:0] capture_high,
    output logic level,
    output logic drives,
    output logic event_pulse,
    output logic match_pulse
);

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] low;
        logic [7:0] high;
        logic level;
        logic event_hit;
        logic match;
    } channel_s;

    channel_s state_q;
    channel_s state_d;
    logic cmp_on;
    logic pwm_on;
    logic equal;
    logic capture;

    always_comb begin
        cmp_on = state_q.mode[counter_array_pkg::COMPARATOR_ENABLE_BIT];
        pwm_on = cmp_on & state_q.mode[counter_array_pkg::MODULATION_BIT];
        equal = ({state_q.high, state_q.low} == count);
        capture = (pin_rise & state_q.mode[counter_array_pkg::RISE_EDGE_ENABLE_BIT])
            | (pin_fall & state_q.mode[counter_array_pkg::FALL_EDGE_ENABLE_BIT]);
        state_d = state_q;
        state_d.event_hit = 1'b0;
        state_d.match = 1'b0;
        if (wr_mode) begin
            state_d.mode = wdata & counter_array_pkg::MODULE_MODE_MASK;
        end
        if (wr_low) begin
            state_d.low = wdata;
        end
        if (wr_high) begin
            state_d.high = wdata;
        end
        // Only a freshly advanced count matches, so a stopped counter hits once
        if (cmp_on && !pwm_on && fresh && equal) begin
            state_d.match = 1'b1;
            if (state_q.mode[counter_array_pkg::COMPARE_HIT_FLAG_ENABLE_BIT]) begin
                state_d.event_hit = 1'b1;
            end
            if (state_q.mode[counter_array_pkg::INVERT_OUTPUT_ON_HIT_BIT]) begin
                state_d.level = ~state_q.level;
            end
        end
        if (capture) begin
            state_d.low = count[7:0];
            state_d.high = count[15:8];
            state_d.event_hit = 1'b1;
        end
        if (pwm_on) begin
            state_d.level = (count[7:0] >= state_q.low);
            // Reload on low byte wrap keeps the duty change glitch free
            if (low_wrap) begin
                state_d.low = state_q.high;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign mode = state_q.mode;
    assign capture_low = state_q.low;
    assign capture_high = state_q.high;
    assign level = state_q.level;
    assign drives = state_q.mode[counter_array_pkg::COMPARATOR_ENABLE_BIT]
        & (state_q.mode[counter_array_pkg::INVERT_OUTPUT_ON_HIT_BIT]
        | state_q.mode[counter_array_pkg::MODULATION_BIT]);
    assign event_pulse = state_q.event_hit;
    assign match_pulse = state_q.match;

endmodule
`default_nettype wire

// File: logic/programmable_counter_array.sv
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module programmable_counter_array (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic idle_mode,
    input wire logic timer0_overflow,
    input wire logic [7:0] port_in,
    input wire logic [7:0] gpio_out,
    input wire logic [7:0] gpio_oe,
    output logic [7:0] port_out,
    output logic [7:0] port_oe,
    output logic irq,
    output logic watchdog_reset
);

    localparam int N = counter_array_pkg::NUM_MODULES;
    localparam int SYNC_W = 8 - counter_array_pkg::EXT_COUNT_PIN;

    typedef struct packed {
        logic [7:0] counter_mode_reg;
        logic run_control;
        logic overflow_flag;
        logic [N-1:0] module_event_flags;
        logic [15:0] count;
        logic [2:0] prescale;
        logic fresh;
        logic low_wrap;
        logic irq;
        logic watchdog_reset;
        logic [7:0] rdata;
        logic [7:0] port_out;
        logic [7:0] port_oe;
    } array_s;

    array_s state_q;
    array_s state_d;

    logic [SYNC_W-1:0] pin_rise;
    logic [SYNC_W-1:0] pin_fall;

    logic [N-1:0][7:0] module_mode_reg;
    logic [N-1:0][7:0] capture_low_reg;
    logic [N-1:0][7:0] capture_high_reg;
    logic [N-1:0] module_level;
    logic [N-1:0] module_drives;
    logic [N-1:0] module_event;
    logic [N-1:0] module_match;
    logic [N-1:0] wr_mode;
    logic [N-1:0] wr_low;
    logic [N-1:0] wr_high;

    logic running;
    logic source_tick;
    logic advance;
    logic [1:0] source_sel;
    logic wr_control;
    logic [N-1:0] irq_sources;

    // External count input and module pins share one synchroniser
    pin_edge_sync #(
        .WIDTH(SYNC_W)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .pins(port_in[7:counter_array_pkg::EXT_COUNT_PIN]),
        .level(),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : g_module
            capture_compare_channel u_channel (
                .clk_sys(clk_sys),
                .reset_n(reset_n),
                .count(state_q.count),
                .fresh(state_q.fresh),
                .low_wrap(state_q.low_wrap),
                .pin_rise(pin_rise[g + 1]),
                .pin_fall(pin_fall[g + 1]),
                .wr_mode(wr_mode[g]),
                .wr_low(wr_low[g]),
                .wr_high(wr_high[g]),
                .wdata(reg_wdata),
                .mode(module_mode_reg[g]),
                .capture_low(capture_low_reg[g]),
                .capture_high(capture_high_reg[g]),
                .level(module_level[g]),
                .drives(module_drives[g]),
                .event_pulse(module_event[g]),
                .match_pulse(module_match[g])
            );
        end
    endgenerate

    // Register write decode
    always_comb begin
        wr_control = reg_wr && (reg_addr == counter_array_pkg::OFS_COUNTER_CONTROL);
        for (int i = 0; i < N; i++) begin
            wr_mode[i] = reg_wr
                && (reg_addr == counter_array_pkg::OFS_MODULE_MODE_BASE + 8'(i));
            wr_low[i] = reg_wr
                && (reg_addr == counter_array_pkg::OFS_CAPTURE_LOW_BASE + 8'(i));
            wr_high[i] = reg_wr
                && (reg_addr == counter_array_pkg::OFS_CAPTURE_HIGH_BASE + 8'(i));
        end
    end

    // Count source and run gating
    always_comb begin
        source_sel = {
            state_q.counter_mode_reg[counter_array_pkg::SOURCE_SELECT_HI_BIT],
            state_q.counter_mode_reg[counter_array_pkg::SOURCE_SELECT_LO_BIT]
        };
        case (counter_array_pkg::count_source_e'(source_sel))
            counter_array_pkg::SRC_CLK_DIV6: begin
                source_tick = (state_q.prescale == counter_array_pkg::PRESCALE_LAST);
            end
            counter_array_pkg::SRC_CLK_DIV2: begin
                source_tick = state_q.prescale[0];
            end
            counter_array_pkg::SRC_TIMER0_OVERFLOW: begin
                source_tick = timer0_overflow;
            end
            counter_array_pkg::SRC_EXTERNAL_INPUT: begin
                // Falling edge of the synchronised external count input
                source_tick = pin_fall[0];
            end
            default: begin
                source_tick = 1'b0;
            end
        endcase
        running = state_q.run_control
            && !(state_q.counter_mode_reg[counter_array_pkg::IDLE_HALT_BIT] && idle_mode);
        advance = running && source_tick;
    end

    // Interrupt sources per module
    always_comb begin
        for (int i = 0; i < N; i++) begin
            irq_sources[i] = state_q.module_event_flags[i]
                & module_mode_reg[i][counter_array_pkg::MODULE_IRQ_ENABLE_BIT];
        end
    end

    always_comb begin
        state_d = state_q;

        // Prescaler free-runs so both divided rates stay in phase
        if (state_q.prescale == counter_array_pkg::PRESCALE_LAST) begin
            state_d.prescale = counter_array_pkg::PRESCALE_ZERO;
        end else begin
            state_d.prescale = state_q.prescale + 3'h1;
        end

        if (reg_wr && reg_addr == counter_array_pkg::OFS_COUNTER_MODE) begin
            state_d.counter_mode_reg = reg_wdata & counter_array_pkg::COUNTER_MODE_MASK;
        end

        // Software can only clear flags; hardware sets below win
        if (wr_control) begin
            state_d.run_control = reg_wdata[counter_array_pkg::RUN_CONTROL_BIT];
            state_d.overflow_flag = state_q.overflow_flag
                & reg_wdata[counter_array_pkg::OVERFLOW_FLAG_BIT];
            state_d.module_event_flags = state_q.module_event_flags
                & reg_wdata[N-1:0];
        end

        state_d.fresh = advance;
        state_d.low_wrap = advance && (state_q.count[7:0] == 8'hff);
        if (advance) begin
            state_d.count = state_q.count + 16'h0001;
            if (state_q.count == 16'hffff) begin
                state_d.overflow_flag = 1'b1;
            end
        end

        // Direct count writes take precedence over the increment
        if (reg_wr && reg_addr == counter_array_pkg::OFS_COUNT_LOW) begin
            state_d.count[7:0] = reg_wdata;
        end
        if (reg_wr && reg_addr == counter_array_pkg::OFS_COUNT_HIGH) begin
            state_d.count[15:8] = reg_wdata;
        end

        state_d.module_event_flags = state_d.module_event_flags | module_event;

        state_d.irq = (state_q.overflow_flag
            & state_q.counter_mode_reg[counter_array_pkg::OVERFLOW_IRQ_ENABLE_BIT])
            | (|irq_sources);

        // Internal reset only; no pin is driven
        state_d.watchdog_reset = module_match[counter_array_pkg::WATCHDOG_MODULE]
            & state_q.counter_mode_reg[counter_array_pkg::WATCHDOG_ENABLE_BIT];

        // Pins pass the port latch unless a module drives them
        state_d.port_out = gpio_out;
        state_d.port_oe = gpio_oe;
        for (int i = 0; i < N; i++) begin
            if (module_drives[i]) begin
                state_d.port_out[counter_array_pkg::MODULE_PIN_BASE + i] = module_level[i];
                state_d.port_oe[counter_array_pkg::MODULE_PIN_BASE + i] = 1'b1;
            end
        end

        // Read data stands one cycle, zero otherwise
        state_d.rdata = counter_array_pkg::RESET_BYTE;
        if (reg_rd) begin
            case (reg_addr)
                counter_array_pkg::OFS_COUNTER_MODE: begin
                    state_d.rdata = state_q.counter_mode_reg;
                end
                counter_array_pkg::OFS_COUNTER_CONTROL: begin
                    state_d.rdata = {state_q.overflow_flag, state_q.run_control, 1'b0,
                        state_q.module_event_flags};
                end
                counter_array_pkg::OFS_COUNT_LOW: begin
                    state_d.rdata = state_q.count[7:0];
                end
                counter_array_pkg::OFS_COUNT_HIGH: begin
                    state_d.rdata = state_q.count[15:8];
                end
                default: begin
                    for (int i = 0; i < N; i++) begin
                        if (reg_addr == counter_array_pkg::OFS_MODULE_MODE_BASE + 8'(i)) begin
                            state_d.rdata = module_mode_reg[i];
                        end
                        if (reg_addr == counter_array_pkg::OFS_CAPTURE_LOW_BASE + 8'(i)) begin
                            state_d.rdata = capture_low_reg[i];
                        end
                        if (reg_addr == counter_array_pkg::OFS_CAPTURE_HIGH_BASE + 8'(i)) begin
                            state_d.rdata = capture_high_reg[i];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign reg_rdata = state_q.rdata;
    assign port_out = state_q.port_out;
    assign port_oe = state_q.port_oe;
    assign irq = state_q.irq;
    assign watchdog_reset = state_q.watchdog_reset;

endmodule
`default_nettype wire

// File: verification/counter_array_pins.sv
`timescale 1ns/1ps
`default_nettype none
module counter_array_pins (
    input wire logic [7:0] port_out,
    input wire logic [7:0] port_oe,
    input wire logic [7:0] want,
    output logic [7:0] port_in
);
    // A pin the array drives reads back its own level, never the far side's
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            port_in[b] = port_oe[b] ? port_out[b] : want[b];
        end
    end
endmodule
`default_nettype wire

// File: verification/programmable_counter_array_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module counter_array_checker (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] gpio_out,
    input wire logic [7:0] gpio_oe,
    input wire logic [7:0] port_out,
    input wire logic [7:0] port_oe,
    input wire logic irq,
    input wire logic watchdog_reset
);
    // Shadows of software writes, since the registers are out of sight
    logic [7:0] mode_q;
    logic [4:0][7:0] mm_q;
    logic [7:0] goe_q;
    logic [4:0] drv;
    logic [4:0] drv_q;
    logic [4:0] drv_qq;
    logic live_q;
    logic [2:0] sel;
    logic any_en;
    logic wdog_ok;

    assign sel = reg_addr[2:0];
    assign wdog_ok = mode_q[6] & mm_q[4][6];
    assign any_en = mode_q[0] | mm_q[0][0] | mm_q[1][0] | mm_q[2][0] | mm_q[3][0] | mm_q[4][0];
    always_comb begin
        for (int n = 0; n < 5; n++) begin
            drv[n] = mm_q[n][6] & (mm_q[n][2] | mm_q[n][1]);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= 8'h00;
            mm_q <= '0;
            goe_q <= 8'h00;
            drv_q <= 5'h00;
            drv_qq <= 5'h00;
            live_q <= 1'b0;
        end else begin
            live_q <= 1'b1;
            goe_q <= gpio_oe;
            drv_q <= drv;
            drv_qq <= drv_q;
            if (reg_wr && reg_addr == 8'h00) begin
                mode_q <= reg_wdata;
            end
            if (reg_wr && reg_addr[7:3] == 5'h01 && sel < 3'h5) begin
                mm_q[sel] <= reg_wdata;
            end
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    sequence s_count_poke;
        reg_wr && reg_addr == 8'h02 ##2 reg_rd && reg_addr == 8'h02;
    endsequence

    a_mode_readback: assert property (
        reg_rd && reg_addr == 8'h00 |=> reg_rdata == (mode_q & 8'hc7))
        else $error("counter mode read back wrong");
    a_module_readback: assert property (
        reg_rd && reg_addr[7:3] == 5'h01 && sel < 3'h5
        |=> reg_rdata == (mm_q[$past(sel)] & 8'h7f))
        else $error("module mode read back wrong");
    a_gpio_pass: assert property (
        live_q |-> ((port_out ^ $past(gpio_out)) & 8'h07) == 8'h00
        && ((port_oe ^ $past(gpio_oe)) & 8'h07) == 8'h00)
        else $error("free pin lost its port latch value");
    a_wdog_gated: assert property (
        watchdog_reset |-> $past(wdog_ok))
        else $error("watchdog reset while disabled");
    a_wdog_single: assert property (
        watchdog_reset |=> !watchdog_reset)
        else $error("watchdog reset longer than one cycle");
    a_irq_gated: assert property (
        irq |-> $past(any_en))
        else $error("interrupt with no source enabled");
    a_count_poke: assert property (
        s_count_poke |=> reg_rdata == $past(reg_wdata, 3)
        || reg_rdata == $past(reg_wdata, 3) + 8'h01)
        else $error("count low byte lost a write");
    for (genvar n = 0; n < 5; n++) begin : g_pin
        a_pin_drive_gate: assert property (
            port_oe[n+3] && !goe_q[n+3] |-> drv[n] || drv_q[n] || drv_qq[n])
            else $error("module pin driven outside output modes");
    end
endmodule

bind programmable_counter_array counter_array_checker u_chk (
    .clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .gpio_out, .gpio_oe, .port_out, .port_oe, .irq, .watchdog_reset
);
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rd_q = 1'b0;
    logic idle_mode = 1'b0;
    logic timer0_overflow = 1'b0;
    logic [7:0] gpio_out = 8'h00;
    logic [7:0] gpio_oe = 8'h00;
    logic [7:0] want = 8'hff;
    logic [7:0] reg_rdata, port_in, port_out, port_oe, r, a;
    logic irq, watchdog_reset;
    logic [7:0] exp_q [$];
    logic [7:0] ra [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08, 8'h09, 8'h0a, 8'h0b,
        8'h0c, 8'h10, 8'h1c, 8'h40};
    logic [7:0] cm [6] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h82, 8'h02};
    logic [7:0] ex [6] = '{8'h0a, 8'h1e, 8'h07, 8'h05, 8'h00, 8'h1e};
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    int wd_seen = 0;
    integer seed = 32'h21fb;

    always #20 clk_sys = ~clk_sys;

    programmable_counter_array u_dut (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .idle_mode, .timer0_overflow, .port_in, .gpio_out, .gpio_oe,
        .port_out, .port_oe, .irq, .watchdog_reset);
    counter_array_pins u_far (.port_out, .port_oe, .want, .port_in);

    task automatic end_sim();
        $display("checks %0d errors %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] x, input logic [15:0] s);
        checked++;
        if (s !== x) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, x, s);
        end
    endtask

    // A read notes its expected byte; the monitor compares it a cycle later
    task automatic acc(input logic w, input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk_sys);
        if (!w) begin
            exp_q.push_back(d);
        end
        reg_addr <= ad;
        reg_wdata <= w ? d : 8'h00;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic cnt(input logic [15:0] v);
        acc(1'b1, 8'h02, v[7:0]);
        acc(1'b1, 8'h03, v[15:8]);
    endtask

    task automatic t0(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            timer0_overflow <= 1'b1;
            @(posedge clk_sys);
            timer0_overflow <= 1'b0;
        end
    endtask

    always @(posedge clk_sys) begin
        gpio_out <= 8'($random(seed));
        gpio_oe <= 8'($random(seed)) & 8'h03;
        rd_q <= reg_rd;
        cycles <= cycles + 1;
        if (watchdog_reset === 1'b1) begin
            wd_seen <= wd_seen + 1;
        end
        if (rd_q) begin
            chk("reg_rdata", 16'(exp_q.pop_front()), 16'(reg_rdata));
        end
        if (cycles == 10000) begin
            fail_count++;
            end_sim();
        end
    end

    initial begin
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        foreach (ra[i]) acc(1'b0, ra[i], 8'h00);
        for (int i = 0; i < 6; i++) begin
            r = 8'($random(seed));
            a = (i == 5) ? 8'h00 : 8'h08 + 8'(i);
            acc(1'b1, a, r);
            acc(1'b0, a, r & ((i == 5) ? 8'hc7 : 8'h7f));
            acc(1'b1, a, 8'h00);
        end
        // Mid-run reset also clears any pin level the random modes left behind
        reset_n <= 1'b0;
        tick(2);
        reset_n <= 1'b1;
        r = 8'($random(seed));
        acc(1'b1, 8'h02, r);
        acc(1'b0, 8'h02, r);
        for (int i = 0; i < 6; i++) begin
            idle_mode <= 1'(i > 3);
            cnt(16'h0000);
            acc(1'b1, 8'h00, cm[i]);
            acc(1'b1, 8'h01, 8'h40);
            if (i == 2) t0(7);
            if (i == 3) begin
                repeat (5) begin
                    want[2] <= 1'b0;
                    tick(3);
                    want[2] <= 1'b1;
                    tick(3);
                end
            end
            tick(58);
            acc(1'b1, 8'h01, 8'h00);
            acc(1'b0, 8'h02, ex[i]);
        end
        idle_mode <= 1'b0;
        cnt(16'hfffe);
        acc(1'b1, 8'h00, 8'h05);
        acc(1'b1, 8'h01, 8'h40);
        t0(2);
        tick(4);
        chk("irq", 16'h0001, 16'(irq));
        acc(1'b0, 8'h01, 8'hc0);
        acc(1'b0, 8'h02, 8'h00);
        acc(1'b1, 8'h00, 8'h04);
        tick(3);
        chk("irq", 16'h0000, 16'(irq));
        acc(1'b1, 8'h01, 8'h00);
        acc(1'b0, 8'h01, 8'h00);
        for (int n = 0; n < 5; n++) begin
            acc(1'b1, 8'h08 + 8'(n), (n == 3) ? 8'h09 : 8'h48 | 8'(n != 2));
            acc(1'b1, 8'h10 + 8'(n), 8'h05);
            acc(1'b1, 8'h18 + 8'(n), 8'h00);
            cnt(16'h0000);
            acc(1'b1, 8'h01, 8'h40);
            t0(5);
            tick(6);
            chk("irq", 16'(n != 2 && n != 3), 16'(irq));
            acc(1'b0, 8'h01, 8'h40 | ((n == 3) ? 8'h00 : 8'h01 << n));
            acc(1'b1, 8'h01, 8'h00);
            acc(1'b0, 8'h01, 8'h00);
            acc(1'b1, 8'h08 + 8'(n), 8'h00);
        end
        acc(1'b1, 8'h11, 8'h03);
        acc(1'b1, 8'h19, 8'h00);
        acc(1'b1, 8'h09, 8'h4c);
        for (int k = 1; k < 3; k++) begin
            cnt(16'h0000);
            acc(1'b1, 8'h01, 8'h40);
            t0(3);
            tick(6);
            chk("pin4", {14'h0, 1'b1, 1'(k)}, {14'h0, port_oe[4], port_out[4]});
            acc(1'b1, 8'h01, 8'h00);
        end
        acc(1'b1, 8'h09, 8'h00);
        cnt(16'h1234);
        acc(1'b1, 8'h0b, 8'h10);
        want[6] <= 1'b0;
        tick(6);
        acc(1'b0, 8'h13, 8'h34);
        acc(1'b0, 8'h1b, 8'h12);
        acc(1'b0, 8'h01, 8'h08);
        cnt(16'h0abc);
        want[6] <= 1'b1;
        tick(6);
        acc(1'b0, 8'h13, 8'h34);
        acc(1'b1, 8'h0b, 8'h20);
        want[6] <= 1'b0;
        tick(6);
        acc(1'b0, 8'h13, 8'h34);
        want[6] <= 1'b1;
        tick(6);
        acc(1'b0, 8'h13, 8'hbc);
        acc(1'b0, 8'h1b, 8'h0a);
        cnt(16'h0077);
        acc(1'b1, 8'h0b, 8'h30);
        want[6] <= 1'b0;
        tick(6);
        acc(1'b0, 8'h13, 8'h77);
        acc(1'b1, 8'h0b, 8'h00);
        acc(1'b1, 8'h14, 8'h02);
        acc(1'b1, 8'h1c, 8'h00);
        acc(1'b1, 8'h0c, 8'h48);
        for (int k = 0; k < 2; k++) begin
            cnt(16'h0000);
            acc(1'b1, 8'h00, (k == 0) ? 8'h44 : 8'h04);
            acc(1'b1, 8'h01, 8'h40);
            t0(3);
            tick(6);
            acc(1'b1, 8'h01, 8'h00);
        end
        chk("watchdog", 16'h0001, 16'(wd_seen));
        acc(1'b1, 8'h10, 8'h80);
        acc(1'b1, 8'h18, 8'h80);
        acc(1'b1, 8'h08, 8'h42);
        cnt(16'h0040);
        tick(4);
        chk("pwm", 16'h0002, {14'h0, port_oe[3], port_out[3]});
        cnt(16'h00c0);
        tick(4);
        chk("pwm", 16'h0003, {14'h0, port_oe[3], port_out[3]});
        acc(1'b1, 8'h18, 8'h20);
        cnt(16'h00fe);
        acc(1'b1, 8'h01, 8'h40);
        t0(2);
        acc(1'b1, 8'h01, 8'h00);
        cnt(16'h0040);
        tick(4);
        chk("pwm", 16'h0003, {14'h0, port_oe[3], port_out[3]});
        end_sim();
    end
endmodule
`default_nettype wire
